// >>> hdl/adc_ctl_pkg.sv
package adc_ctl_pkg;

	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int SEQ_N    = 4;
	localparam int PRIO_W   = 2;
	localparam int AVG_W    = 3;
	localparam int SAMPLE_W = 12;
	localparam int AVG_MAX  = 6;
	localparam int ACC_W    = SAMPLE_W + AVG_MAX;
	localparam int CNT_W    = AVG_MAX;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] PRIO_OFS = 12'h020;
	localparam logic [ADDR_W-1:0] INIT_OFS = 12'h028;
	localparam logic [ADDR_W-1:0] AVG_OFS  = 12'h030;
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h034;

	// Field layout
	localparam int PRIO_STRIDE  = 4;
	localparam int INIT_LSB     = 0;
	localparam int AVG_LSB      = 0;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_SEQ_LSB = 4;
	localparam int STAT_PND_LSB = 8;
	localparam logic [15:0] PRIO_MASK = 16'h3333;

	// Reset values
	localparam logic [15:0]      PRIO_RST = 16'h3210;
	localparam logic [AVG_W-1:0] AVG_RST  = 3'h0;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

	typedef struct packed {
		logic [1:0]          seq;
		logic [SAMPLE_W-1:0] data;
	} result_t;

endpackage

// >>> hdl/adc_seq_arb.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module adc_seq_arb (
	input  wire logic                                mclk,          // 20 MHz
	input  wire logic                                arst_n,        // Async reset
	input  wire logic [adc_ctl_pkg::ADDR_W-1:0]      s_axi_awaddr,  // AW addr
	input  wire logic                                s_axi_awvalid, // AW valid
	output logic                                     s_axi_awready, // AW ready
	input  wire logic [adc_ctl_pkg::DATA_W-1:0]      s_axi_wdata,   // W data
	input  wire logic [3:0]                          s_axi_wstrb,   // W strobes
	input  wire logic                                s_axi_wvalid,  // W valid
	output logic                                     s_axi_wready,  // W ready
	output logic [1:0]                               s_axi_bresp,   // B resp
	output logic                                     s_axi_bvalid,  // B valid
	input  wire logic                                s_axi_bready,  // B ready
	input  wire logic [adc_ctl_pkg::ADDR_W-1:0]      s_axi_araddr,  // AR addr
	input  wire logic                                s_axi_arvalid, // AR valid
	output logic                                     s_axi_arready, // AR ready
	output logic [adc_ctl_pkg::DATA_W-1:0]           s_axi_rdata,   // R data
	output logic [1:0]                               s_axi_rresp,   // R resp
	output logic                                     s_axi_rvalid,  // R valid
	input  wire logic                                s_axi_rready,  // R ready
	input  wire logic [adc_ctl_pkg::SEQ_N-1:0]       sequencer_active_enables, // En
	output logic                                     conv_req,      // Want samples
	output logic [1:0]                               active_seq,    // Running seq
	input  wire logic                                conv_valid,    // Sample strobe
	input  wire logic [adc_ctl_pkg::SAMPLE_W-1:0]    conv_data,     // Sample value
	output logic                                     result_valid,  // FIFO push
	output adc_ctl_pkg::result_t                     result         // FIFO entry
);

	// Priority field of one sequencer
	function automatic logic [1:0] prio_of(input logic [15:0] map, input int i);
		return map[i*adc_ctl_pkg::PRIO_STRIDE +: adc_ctl_pkg::PRIO_W];
	endfunction

	// Word-aligned address match
	function automatic logic hit(
		input logic [adc_ctl_pkg::ADDR_W-1:0] a,
		input logic [adc_ctl_pkg::ADDR_W-1:0] ofs
	);
		return a[adc_ctl_pkg::ADDR_W-1:2] == ofs[adc_ctl_pkg::ADDR_W-1:2];
	endfunction

	// Lowest priority value among candidates wins
	function automatic logic [1:0] pick_winner(
		input logic [3:0]  cand,
		input logic [15:0] map
	);
		logic [1:0] best;
		logic [2:0] best_p;
		best   = 2'h0;
		best_p = 3'h4;
		for (int i = 0; i < adc_ctl_pkg::SEQ_N; i++) begin
			if (cand[i] && {1'b0, prio_of(map, i)} < best_p) begin
				best   = 2'(i);
				best_p = {1'b0, prio_of(map, i)};
			end
		end
		return best;
	endfunction

	// Bus state
	logic                               aw_hold_ff, nxt_aw_hold;
	logic [adc_ctl_pkg::ADDR_W-1:0]     aw_addr_ff, nxt_aw_addr;
	logic                               w_hold_ff, nxt_w_hold;
	logic [adc_ctl_pkg::DATA_W-1:0]     w_data_ff, nxt_w_data;
	logic [3:0]                         w_strb_ff, nxt_w_strb;
	logic                               awready_ff, nxt_awready;
	logic                               wready_ff, nxt_wready;
	logic                               bvalid_ff, nxt_bvalid;
	logic [1:0]                         bresp_ff, nxt_bresp;
	logic                               arready_ff, nxt_arready;
	logic                               rvalid_ff, nxt_rvalid;
	logic [adc_ctl_pkg::DATA_W-1:0]     rdata_ff, nxt_rdata;
	logic [1:0]                         rresp_ff, nxt_rresp;
	logic [15:0]                        prio_ff, nxt_prio;
	logic [adc_ctl_pkg::AVG_W-1:0]      avg_ff, nxt_avg;

	// Sequencing state
	adc_ctl_pkg::run_state_t            st_ff, nxt_st;
	logic [3:0]                         pend_ff, nxt_pend;
	logic [1:0]                         cur_ff, nxt_cur;
	logic [adc_ctl_pkg::AVG_W-1:0]      avg_run_ff, nxt_avg_run;
	logic [adc_ctl_pkg::CNT_W-1:0]      cnt_ff, nxt_cnt;
	logic [adc_ctl_pkg::ACC_W-1:0]      acc_ff, nxt_acc;
	logic                               req_ff, nxt_req;
	logic                               res_v_ff, nxt_res_v;
	adc_ctl_pkg::result_t               res_ff, nxt_res;

	logic                               do_wr, ar_take;
	logic [3:0]                         trig, cand;
	logic [1:0]                         win;
	logic [adc_ctl_pkg::CNT_W-1:0]      last;
	logic [adc_ctl_pkg::ACC_W-1:0]      sum;

	assign do_wr   = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign ar_take = s_axi_arvalid && arready_ff;

	// Bus channels: address and data held separately, either order
	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_hold  = w_hold_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_bvalid  = bvalid_ff && !s_axi_bready;
		nxt_bresp   = bresp_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_hold = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_hold = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (do_wr) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = (hit(aw_addr_ff, adc_ctl_pkg::PRIO_OFS) ||
				hit(aw_addr_ff, adc_ctl_pkg::INIT_OFS) ||
				hit(aw_addr_ff, adc_ctl_pkg::AVG_OFS) ||
				hit(aw_addr_ff, adc_ctl_pkg::STAT_OFS)) ?
				adc_ctl_pkg::RESP_OKAY : adc_ctl_pkg::RESP_SLVERR;
		end
		nxt_awready = !nxt_aw_hold;
		nxt_wready  = !nxt_w_hold;
	end

	// Register writes; reserved bits are dropped and read as zero
	always_comb begin
		nxt_prio = prio_ff;
		nxt_avg  = avg_ff;
		if (do_wr && hit(aw_addr_ff, adc_ctl_pkg::PRIO_OFS)) begin
			for (int b = 0; b < 2; b++) begin
				if (w_strb_ff[b])
					nxt_prio[b*8 +: 8] = w_data_ff[b*8 +: 8];
			end
			nxt_prio = nxt_prio & adc_ctl_pkg::PRIO_MASK;
		end
		if (do_wr && hit(aw_addr_ff, adc_ctl_pkg::AVG_OFS) && w_strb_ff[0])
			nxt_avg = w_data_ff[adc_ctl_pkg::AVG_LSB +: adc_ctl_pkg::AVG_W];
	end

	// Read path; the initiate word reads zero
	always_comb begin
		nxt_rvalid  = rvalid_ff && !s_axi_rready;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (ar_take) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = '0;
			nxt_rresp  = adc_ctl_pkg::RESP_OKAY;
			if (hit(s_axi_araddr, adc_ctl_pkg::PRIO_OFS))
				nxt_rdata[15:0] = prio_ff;
			else if (hit(s_axi_araddr, adc_ctl_pkg::AVG_OFS))
				nxt_rdata[adc_ctl_pkg::AVG_LSB +: adc_ctl_pkg::AVG_W] = avg_ff;
			else if (hit(s_axi_araddr, adc_ctl_pkg::STAT_OFS)) begin
				nxt_rdata[adc_ctl_pkg::STAT_BUSY]         = st_ff == adc_ctl_pkg::ST_RUN;
				nxt_rdata[adc_ctl_pkg::STAT_SEQ_LSB +: 2] = cur_ff;
				nxt_rdata[adc_ctl_pkg::STAT_PND_LSB +: 4] = pend_ff;
			end
			else if (!hit(s_axi_araddr, adc_ctl_pkg::INIT_OFS))
				nxt_rresp = adc_ctl_pkg::RESP_SLVERR;
		end
		nxt_arready = !nxt_rvalid;
	end

	// Enabled triggers from one initiate write, any subset
	always_comb begin
		trig = '0;
		if (do_wr && hit(aw_addr_ff, adc_ctl_pkg::INIT_OFS) && w_strb_ff[0])
			trig = w_data_ff[adc_ctl_pkg::INIT_LSB +: 4] &
				sequencer_active_enables;
	end

	assign cand = pend_ff & sequencer_active_enables;
	assign win  = pick_winner(cand, prio_ff);
	assign last = adc_ctl_pkg::CNT_W'((7'h1 << avg_run_ff) - 7'h1);
	assign sum  = acc_ff + adc_ctl_pkg::ACC_W'(conv_data);

	// Arbiter and averager; new triggers win over a grant clear
	always_comb begin
		nxt_st      = st_ff;
		nxt_cur     = cur_ff;
		nxt_avg_run = avg_run_ff;
		nxt_cnt     = cnt_ff;
		nxt_acc     = acc_ff;
		nxt_req     = req_ff;
		nxt_res_v   = 1'b0;
		nxt_res     = res_ff;
		nxt_pend    = cand;
		unique case (st_ff)
			adc_ctl_pkg::ST_IDLE: begin
				if (|cand) begin
					nxt_st         = adc_ctl_pkg::ST_RUN;
					nxt_cur        = win;
					nxt_pend[win]  = 1'b0;
					nxt_avg_run    = avg_ff;
					nxt_cnt        = '0;
					nxt_acc        = '0;
					nxt_req        = 1'b1;
				end
			end
			adc_ctl_pkg::ST_RUN: begin
				if (conv_valid) begin
					if (cnt_ff == last) begin
						nxt_st       = adc_ctl_pkg::ST_IDLE;
						nxt_req      = 1'b0;
						nxt_res_v    = 1'b1;
						nxt_res.seq  = cur_ff;
						// Shift by exponent gives the mean for 0 to 6 (7 takes 64 samples, shifts by 7); zero passes raw
						nxt_res.data = adc_ctl_pkg::SAMPLE_W'(sum >> avg_run_ff);
					end
					else begin
						nxt_cnt = cnt_ff + 1'b1;
						nxt_acc = sum;
					end
				end
			end
		endcase
		nxt_pend = nxt_pend | trig;
	end

	// All state registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_hold_ff  <= 1'b0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= adc_ctl_pkg::RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= adc_ctl_pkg::RESP_OKAY;
			prio_ff    <= adc_ctl_pkg::PRIO_RST;
			avg_ff     <= adc_ctl_pkg::AVG_RST;
			st_ff      <= adc_ctl_pkg::ST_IDLE;
			pend_ff    <= '0;
			cur_ff     <= '0;
			avg_run_ff <= '0;
			cnt_ff     <= '0;
			acc_ff     <= '0;
			req_ff     <= 1'b0;
			res_v_ff   <= 1'b0;
			res_ff     <= '0;
		end
		else begin
			aw_hold_ff <= nxt_aw_hold;
			aw_addr_ff <= nxt_aw_addr;
			w_hold_ff  <= nxt_w_hold;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
			prio_ff    <= nxt_prio;
			avg_ff     <= nxt_avg;
			st_ff      <= nxt_st;
			pend_ff    <= nxt_pend;
			cur_ff     <= nxt_cur;
			avg_run_ff <= nxt_avg_run;
			cnt_ff     <= nxt_cnt;
			acc_ff     <= nxt_acc;
			req_ff     <= nxt_req;
			res_v_ff   <= nxt_res_v;
			res_ff     <= nxt_res;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign conv_req      = req_ff;
	assign active_seq    = cur_ff;
	assign result_valid  = res_v_ff;
	assign result        = res_ff;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Winner holds the smallest value among candidates
	logic win_min;
	always_comb begin
		win_min = 1'b1;
		for (int j = 0; j < adc_ctl_pkg::SEQ_N; j++) begin
			if (cand[j] && prio_of(prio_ff, j) < prio_of(prio_ff, int'(win)))
				win_min = 1'b0;
		end
	end

	sequence s_grant;
		st_ff == adc_ctl_pkg::ST_IDLE && |cand;
	endsequence
	sequence s_last_sample;
		st_ff == adc_ctl_pkg::ST_RUN && conv_valid && cnt_ff == last;
	endsequence

	property p_prio_min;
		|cand |-> win_min;
	endproperty
	a_prio_min: assert property (p_prio_min) else $error("winner not minimal");

	property p_prio_hold;
		!(do_wr && hit(aw_addr_ff, adc_ctl_pkg::PRIO_OFS)) |=> $stable(prio_ff);
	endproperty
	a_prio_hold: assert property (p_prio_hold) else $error("priority drifted");

	property p_trig_pend;
		|trig |=> ((pend_ff | (4'h1 << cur_ff)) & $past(trig)) == $past(trig);
	endproperty
	a_trig_pend: assert property (p_trig_pend) else $error("trigger lost");

	property p_no_trig;
		st_ff == adc_ctl_pkg::ST_IDLE && cand == 4'h0 && trig == 4'h0
			|=> st_ff == adc_ctl_pkg::ST_IDLE && pend_ff == 4'h0;
	endproperty
	a_no_trig: assert property (p_no_trig) else $error("spurious start");

	property p_grant;
		s_grant |=> st_ff == adc_ctl_pkg::ST_RUN && cur_ff == $past(win) && req_ff;
	endproperty
	a_grant: assert property (p_grant) else $error("bad grant");

	property p_pass;
		s_last_sample and avg_run_ff == 3'h0
			|=> res_v_ff && res_ff.data == $past(conv_data);
	endproperty
	a_pass: assert property (p_pass) else $error("raw sample changed");

	property p_avg_end;
		s_last_sample |=> res_v_ff ##1 !res_v_ff;
	endproperty
	a_avg_end: assert property (p_avg_end) else $error("no single result");

	property p_avg_count;
		s_last_sample and avg_run_ff == 3'h6 |-> cnt_ff == 6'h3F;
	endproperty
	a_avg_count: assert property (p_avg_count) else $error("not 64 samples");

	property p_init_read;
		ar_take && hit(s_axi_araddr, adc_ctl_pkg::INIT_OFS)
			|=> rvalid_ff && rdata_ff == 32'h0;
	endproperty
	a_init_read: assert property (p_init_read) else $error("initiate read");

endmodule

// >>> testbench/adc_sequencer_priority_trigger_avg_tb.sv
`timescale 1ns/1ps
module adc_sequencer_priority_trigger_avg_tb;
	logic                 mclk;
	logic                 arst_n;
	logic [11:0]          awaddr;
	logic [11:0]          araddr;
	logic [11:0]          cdata;
	logic [31:0]          wdata;
	logic [31:0]          rdata;
	logic [3:0]           en;
	logic                 awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	logic [1:0]           bresp, rresp, aseq;
	logic                 creq, cv, resv;
	adc_ctl_pkg::result_t res;
	int                   n_mismatch, n_tests;

	adc_seq_arb DUT (
		.mclk(mclk), .arst_n(arst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr),
		.sequencer_active_enables(en), .conv_req(creq),
		.active_seq(aseq), .conv_valid(cv), .conv_data(cdata),
		.result_valid(resv), .result(res)
	);

	// Free-running 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic final_report();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tmo(input string m);
		n_mismatch++;
		$display("BAD t=%0t timeout %s", $time, m);
		final_report();
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [1:0] er);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			@(posedge mclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_rdy)
				wv <= 1'b0;
			if (bv) begin
				br <= 1'b0;
				chk(32'(bresp), 32'(er), "bresp");
				return;
			end
		end
		tmo("write");
	endtask

	// Mask keeps reserved bits out of the compare
	task automatic rd(input logic [11:0] a, input logic [31:0] ex, mk,
			input logic [1:0] er);
		@(posedge mclk);
		araddr <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			@(posedge mclk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv) begin
				rr <= 1'b0;
				chk(rdata & mk, ex, "rdata");
				chk(32'(rresp), 32'(er), "rresp");
				return;
			end
		end
		tmo("read");
	endtask

	// Grant of seq s, then 2^avg samples, then one averaged result
	task automatic run_seq(input logic [1:0] s, input int avg,
			input logic [11:0] base);
		logic [31:0] sum;
		logic [11:0] v;
		logic [11:0] m;
		sum = 32'h0;
		for (int k = 0; k < 20 && creq !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		if (creq !== 1'b1)
			tmo("grant");
		chk(32'(aseq), 32'(s), "active seq");
		for (int k = 0; k < (1 << avg); k++) begin
			v = base + 12'(k * 37);
			sum = sum + 32'(v);
			@(posedge mclk);
			cv <= 1'b1;
			cdata <= v;
		end
		@(posedge mclk);
		cv <= 1'b0;
		m = 12'(sum >> avg);
		for (int k = 0; k < 4; k++) begin
			#1;
			if (resv === 1'b1)
				break;
			@(posedge mclk);
		end
		chk(32'({resv, creq, res}), {16'h0, 1'b1, 1'b0, s, m}, "result");
	endtask

	// No grant may appear for n cycles
	task automatic no_req(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge mclk);
			#1;
			chk(32'(creq), 32'h0, "idle");
		end
	endtask

	task automatic t_reset();
		rd(adc_ctl_pkg::PRIO_OFS, 32'h3210, 32'h3333, 2'h0);
		rd(adc_ctl_pkg::AVG_OFS, 32'h0, 32'h7, 2'h0);
		en <= 4'hF;
		wr(adc_ctl_pkg::INIT_OFS, 32'hC, 2'h0);
		run_seq(2'h2, 0, 12'h5A3);
		run_seq(2'h3, 0, 12'hA5C);
		$display("test reset done");
	endtask

	// Scrambled map: seq1 first, then 3, 0, 2
	task automatic t_prio();
		wr(adc_ctl_pkg::PRIO_OFS, 32'h1302, 2'h0);
		rd(adc_ctl_pkg::PRIO_OFS, 32'h1302, 32'h3333, 2'h0);
		wr(adc_ctl_pkg::INIT_OFS, 32'hF, 2'h0);
		run_seq(2'h1, 0, 12'h001);
		run_seq(2'h3, 0, 12'hFFF);
		run_seq(2'h0, 0, 12'h800);
		run_seq(2'h2, 0, 12'h7FE);
		$display("test prio done");
	endtask

	task automatic t_avg();
		wr(adc_ctl_pkg::AVG_OFS, 32'h2, 2'h0);
		rd(adc_ctl_pkg::AVG_OFS, 32'h2, 32'h7, 2'h0);
		wr(adc_ctl_pkg::INIT_OFS, 32'h2, 2'h0);
		run_seq(2'h1, 2, 12'hF00);
		wr(adc_ctl_pkg::AVG_OFS, 32'h6, 2'h0);
		wr(adc_ctl_pkg::INIT_OFS, 32'h8, 2'h0);
		run_seq(2'h3, 6, 12'hC40);
		wr(adc_ctl_pkg::AVG_OFS, 32'h0, 2'h0);
		$display("test avg done");
	endtask

	// Disabled and zero triggers vanish; initiate reads start nothing
	task automatic t_disc();
		en <= 4'h5;
		wr(adc_ctl_pkg::INIT_OFS, 32'hF, 2'h0);
		// Status mid-run: busy, seq0 running, only seq2 still pending
		rd(adc_ctl_pkg::STAT_OFS, 32'h401, 32'hFFFFFFFF, 2'h0);
		run_seq(2'h0, 0, 12'h123);
		run_seq(2'h2, 0, 12'h321);
		no_req(8);
		wr(adc_ctl_pkg::INIT_OFS, 32'h0, 2'h0);
		no_req(8);
		rd(adc_ctl_pkg::INIT_OFS, 32'h0, 32'hFFFFFFFF, 2'h0);
		no_req(4);
		rd(12'h0FC, 32'h0, 32'hFFFFFFFF, 2'h2);
		wr(12'h0FC, 32'hF, 2'h2);
		no_req(4);
		$display("test discard done");
	endtask

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		arst_n = 1'b0;
		awaddr = 12'h0;
		araddr = 12'h0;
		wdata = 32'h0;
		awv = 1'b0;
		wv = 1'b0;
		br = 1'b0;
		arv = 1'b0;
		rr = 1'b0;
		en = 4'h0;
		cv = 1'b0;
		cdata = 12'h0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_prio();
		t_avg();
		t_disc();
		final_report();
	end
endmodule
